// ===== hw/twm_pkg.sv
// Constants, state type and register layout of the two-wire master transmitter
package twm_pkg;
  // Register indices on the plain register port
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  localparam logic [1:0] ADDR_DATA = 2'h2;
  // Control register bit positions
  localparam int CTL_DONE  = 7;
  localparam int CTL_ACKEN = 6;
  localparam int CTL_STA   = 5;
  localparam int CTL_STO   = 4;
  localparam int CTL_WCOL  = 3;
  localparam int CTL_EN    = 2;
  localparam int CTL_IE    = 0;
  // Reset values, masks and the last bit index
  localparam logic [7:0] DATA_RST   = 8'hFF;
  localparam logic [7:0] CODE_RST   = 8'hF8;
  localparam logic [7:0] STAT_MASK  = 8'hF8;
  localparam logic [1:0] PRESC_RST  = 2'h0;
  localparam logic [2:0] LAST_BIT   = 3'h7;
  // Status codes, prescaler bits zero
  localparam logic [7:0] SC_START   = 8'h08;
  localparam logic [7:0] SC_RSTART  = 8'h10;
  localparam logic [7:0] SC_ADR_ACK = 8'h18;
  localparam logic [7:0] SC_ADR_NAK = 8'h20;
  localparam logic [7:0] SC_DAT_ACK = 8'h28;
  localparam logic [7:0] SC_DAT_NAK = 8'h30;
  localparam logic [7:0] SC_ARB_LOST = 8'h38;
  // Sequencer states, one-hot
  typedef enum logic [13:0] {
    S_IDLE      = 14'h0001,
    S_START     = 14'h0002,
    S_START_END = 14'h0004,
    S_HOLD      = 14'h0008,
    S_BIT_L     = 14'h0010,
    S_BIT_H     = 14'h0020,
    S_ACK_L     = 14'h0040,
    S_ACK_H     = 14'h0080,
    S_STOP_A    = 14'h0100,
    S_STOP_B    = 14'h0200,
    S_STOP_C    = 14'h0400,
    S_RS_A      = 14'h0800,
    S_RS_B      = 14'h1000,
    S_LOST      = 14'h2000
  } twm_state_t;
endpackage

// ===== hw/twm_sync.sv
// Two-stage synchroniser for asynchronous bus pin levels
`timescale 1ns/100ps
module twm_sync #(
  parameter int W = 2
) (
  input  wire logic         clock,  // System clock
  input  wire logic         rst,    // Async reset, active high
  input  wire logic [W-1:0] din,    // Asynchronous levels
  output logic      [W-1:0] dout    // Synchronised levels
);
  logic [W-1:0] meta_r;

  // Reset to all ones, the idle level of an open-drain bus
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= '1;
      dout   <= '1;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule

// ===== hw/twm_master.sv
// Two-wire master transmitter: registers, bus sequencer and pin drivers
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module twm_master #(
  parameter int BR_W = 8
) (
  input  wire logic            clock,     // System clock, 25 MHz
  input  wire logic            rst,       // Async reset, active high
  input  wire logic [1:0]      addr,      // Register index
  input  wire logic [7:0]      wdata,     // Write data
  input  wire logic            wr,        // Write strobe
  input  wire logic            rd,        // Read strobe
  output logic      [7:0]      rdata,     // Read data, cycle after rd
  input  wire logic [BR_W-1:0] bit_rate,  // SCL phase length minus one
  input  wire logic            scl_i,     // SCL pin level
  output logic                 scl_o,     // SCL drive value
  output logic                 scl_oe,    // SCL pulled low when high
  input  wire logic            sda_i,     // SDA pin level
  output logic                 sda_o,     // SDA drive value
  output logic                 sda_oe     // SDA pulled low when high
);
  twm_pkg::twm_state_t state_r;
  twm_pkg::twm_state_t state_nxt;
  logic            done_r, ack_en_r, sta_r, sto_r, wcol_r, en_r, ie_r;
  logic [7:0]      data_r, code_r, code_nxt, shift_r, rdata_r;
  logic [1:0]      presc_r;
  logic [2:0]      bit_cnt_r;
  logic [BR_W-1:0] tmr_r;
  logic            scl_s, sda_s, sda_d_r, busy_r, addr_ph_r, rs_r;
  logic            scl_oe_r, sda_oe_r;
  logic            phase_done, high_wait, set_done, lost_evt;
  logic            wr_ctrl, wr_stat, wr_data;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus-busy tracking

  // Both pins come from outside the clock domain
  twm_sync #(.W(2)) u_sync (
    .clock (clock),
    .rst   (rst),
    .din   ({scl_i, sda_i}),
    .dout  ({scl_s, sda_s})
  );

  // Watch START and STOP from any master, ours included
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sda_d_r <= 1'b1;
      busy_r  <= 1'b0;
    end else begin
      sda_d_r <= sda_s;
      if (scl_s && sda_d_r && !sda_s) begin
        busy_r <= 1'b1;
      end else if (scl_s && !sda_d_r && sda_s) begin
        busy_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  assign wr_ctrl = wr && (addr == twm_pkg::ADDR_CTRL);
  assign wr_stat = wr && (addr == twm_pkg::ADDR_STAT);
  assign wr_data = wr && (addr == twm_pkg::ADDR_DATA);

  // Control bits; hardware set of the flag wins over a software clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done_r  <= 1'b0;
      ack_en_r <= 1'b0;
      sta_r   <= 1'b0;
      sto_r   <= 1'b0;
      en_r    <= 1'b0;
      ie_r    <= 1'b0;
    end else begin
      if (state_r == twm_pkg::S_STOP_C) begin
        sto_r <= 1'b0;
      end
      if (wr_ctrl) begin
        ack_en_r <= wdata[twm_pkg::CTL_ACKEN];
        sta_r   <= wdata[twm_pkg::CTL_STA];
        sto_r   <= wdata[twm_pkg::CTL_STO];
        en_r    <= wdata[twm_pkg::CTL_EN];
        ie_r    <= wdata[twm_pkg::CTL_IE];
        if (wdata[twm_pkg::CTL_DONE]) begin
          done_r <= 1'b0;
        end
      end
      if (set_done) begin
        done_r <= 1'b1;
      end
    end
  end

  // Data register; writes while the unit is busy are discarded
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_r <= twm_pkg::DATA_RST;
      wcol_r <= 1'b0;
    end else if (wr_data) begin
      if (done_r) begin
        data_r <= wdata;
        wcol_r <= 1'b0;
      end else begin
        wcol_r <= 1'b1;
      end
    end
  end

  // Status code and prescaler field
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      code_r  <= twm_pkg::CODE_RST;
      presc_r <= twm_pkg::PRESC_RST;
    end else begin
      if (set_done) begin
        code_r <= code_nxt;
      end
      if (wr_stat) begin
        presc_r <= wdata[1:0];
      end
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (rd) begin
      case (addr)
        twm_pkg::ADDR_CTRL: rdata_r <= {done_r, ack_en_r, sta_r, sto_r,
                                        wcol_r, en_r, 1'b0, ie_r};
        twm_pkg::ADDR_STAT: rdata_r <= (code_r & twm_pkg::STAT_MASK) | {6'h00, presc_r};
        twm_pkg::ADDR_DATA: rdata_r <= data_r;
        default:            rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Phase timer

  // The S_BIT_H, S_ACK_H, S_STOP_B and S_RS_B high phases wait for SCL to read high, so a slave may stretch
  assign high_wait  = (state_r == twm_pkg::S_BIT_H) || (state_r == twm_pkg::S_ACK_H) ||
                      (state_r == twm_pkg::S_STOP_B) || (state_r == twm_pkg::S_RS_B);
  assign phase_done = (tmr_r >= bit_rate) && (!high_wait || scl_s);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tmr_r <= '0;
    end else if (state_nxt != state_r) begin
      tmr_r <= '0;
    end else if ((!high_wait || scl_s) && (tmr_r < bit_rate)) begin
      tmr_r <= tmr_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus sequencer

  // Arbitration is lost when a released SDA reads low during the SCL high phase of a byte bit
  assign lost_evt = (state_r == twm_pkg::S_BIT_H) && scl_s && shift_r[7] && !sda_s;

  // Flag-setting events and their codes
  always_comb begin
    set_done = 1'b0;
    code_nxt = code_r;
    if (lost_evt) begin
      set_done = 1'b1;
      code_nxt = twm_pkg::SC_ARB_LOST;
    end else if ((state_r == twm_pkg::S_START_END) && phase_done) begin
      set_done = 1'b1;
      code_nxt = rs_r ? twm_pkg::SC_RSTART : twm_pkg::SC_START;
    end else if ((state_r == twm_pkg::S_ACK_H) && phase_done) begin
      set_done = 1'b1;
      if (addr_ph_r) begin
        code_nxt = sda_s ? twm_pkg::SC_ADR_NAK : twm_pkg::SC_ADR_ACK;
      end else begin
        code_nxt = sda_s ? twm_pkg::SC_DAT_NAK : twm_pkg::SC_DAT_ACK;
      end
    end
  end

  // Next state; a step starts only after software clears the flag
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      twm_pkg::S_IDLE:      if (!done_r && sta_r && !busy_r) state_nxt = twm_pkg::S_START;
      twm_pkg::S_START:     if (phase_done) state_nxt = twm_pkg::S_START_END;
      twm_pkg::S_START_END: if (phase_done) state_nxt = twm_pkg::S_HOLD;
      twm_pkg::S_HOLD: begin
        if (!done_r) begin
          if (sto_r) begin
            state_nxt = twm_pkg::S_STOP_A;
          end else if (sta_r) begin
            state_nxt = twm_pkg::S_RS_A;
          end else begin
            state_nxt = twm_pkg::S_BIT_L;
          end
        end
      end
      twm_pkg::S_BIT_L:     if (phase_done) state_nxt = twm_pkg::S_BIT_H;
      twm_pkg::S_BIT_H: begin
        if (lost_evt) begin
          state_nxt = twm_pkg::S_LOST;
        end else if (phase_done) begin
          state_nxt = (bit_cnt_r == twm_pkg::LAST_BIT) ? twm_pkg::S_ACK_L
                                                       : twm_pkg::S_BIT_L;
        end
      end
      twm_pkg::S_ACK_L:     if (phase_done) state_nxt = twm_pkg::S_ACK_H;
      twm_pkg::S_ACK_H:     if (phase_done) state_nxt = twm_pkg::S_HOLD;
      twm_pkg::S_STOP_A:    if (phase_done) state_nxt = twm_pkg::S_STOP_B;
      twm_pkg::S_STOP_B:    if (phase_done) state_nxt = twm_pkg::S_STOP_C;
      twm_pkg::S_STOP_C:    if (phase_done) state_nxt = twm_pkg::S_IDLE;
      twm_pkg::S_RS_A:      if (phase_done) state_nxt = twm_pkg::S_RS_B;
      twm_pkg::S_RS_B:      if (phase_done) state_nxt = twm_pkg::S_START;
      twm_pkg::S_LOST:      if (!done_r) state_nxt = twm_pkg::S_IDLE;
      default:              state_nxt = twm_pkg::S_IDLE;
    endcase
    if (!en_r) begin
      state_nxt = twm_pkg::S_IDLE;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= twm_pkg::S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Shifter, bit counter, address-phase and restart markers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shift_r   <= twm_pkg::DATA_RST;
      bit_cnt_r <= 3'h0;
      addr_ph_r <= 1'b0;
      rs_r      <= 1'b0;
    end else begin
      if ((state_r == twm_pkg::S_HOLD) && (state_nxt == twm_pkg::S_BIT_L)) begin
        shift_r   <= data_r;
        bit_cnt_r <= 3'h0;
      end else if ((state_r == twm_pkg::S_BIT_H) && phase_done && !lost_evt) begin
        shift_r   <= {shift_r[6:0], 1'b1};
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      if ((state_r == twm_pkg::S_START_END) && phase_done) begin
        addr_ph_r <= 1'b1;
      end else if (((state_r == twm_pkg::S_ACK_H) && phase_done) || lost_evt) begin
        addr_ph_r <= 1'b0;
      end
      if (state_r == twm_pkg::S_RS_B) begin
        rs_r <= 1'b1;
      end else if (state_r == twm_pkg::S_IDLE) begin
        rs_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain drivers, registered from the next state

  // SCL stays low in the hold state until the flag clears
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_nxt)
        twm_pkg::S_START_END, twm_pkg::S_HOLD, twm_pkg::S_BIT_L,
        twm_pkg::S_ACK_L, twm_pkg::S_STOP_A, twm_pkg::S_RS_A:
          scl_oe_r <= 1'b1;
        default:
          scl_oe_r <= 1'b0;
      endcase
      case (state_nxt)
        twm_pkg::S_START, twm_pkg::S_START_END, twm_pkg::S_HOLD,
        twm_pkg::S_STOP_A, twm_pkg::S_STOP_B:
          sda_oe_r <= 1'b1;
        twm_pkg::S_BIT_L:
          // SDA changes with the falling SCL and must not move while SCL is high, or the slave sees a START or STOP
          sda_oe_r <= (state_r == twm_pkg::S_HOLD)  ? !data_r[7] :
                      (state_r == twm_pkg::S_BIT_H) ? !shift_r[6] : !shift_r[7];
        twm_pkg::S_BIT_H:
          sda_oe_r <= !shift_r[7];
        default:
          sda_oe_r <= 1'b0;
      endcase
    end
  end
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_flag_clear_one: assert property (@(posedge clock) disable iff (rst)
    (wr_ctrl && wdata[twm_pkg::CTL_DONE] && !set_done) |=> !done_r)
    else $error("done flag not cleared by write of one");

  a_flag_zero_keep: assert property (@(posedge clock) disable iff (rst)
    (wr_ctrl && !wdata[twm_pkg::CTL_DONE] && !done_r && !set_done) |=> !done_r)
    else $error("done flag set by write of zero");

  a_wcol_on_busy: assert property (@(posedge clock) disable iff (rst)
    (wr_data && !done_r) |=> (wcol_r && data_r == $past(data_r)))
    else $error("data write during busy not discarded");

  a_disabled_quiet: assert property (@(posedge clock) disable iff (rst)
    !en_r |=> (!scl_oe && !sda_oe && state_r == twm_pkg::S_IDLE))
    else $error("bus driven while interface disabled");

  a_start_bus_free: assert property (@(posedge clock) disable iff (rst)
    (state_r == twm_pkg::S_IDLE) ##1 (state_r == twm_pkg::S_START) |->
      (!$past(busy_r) && $past(sta_r) && !$past(done_r)))
    else $error("START issued on busy bus");

  a_start_code: assert property (@(posedge clock) disable iff (rst)
    ((state_r == twm_pkg::S_START_END) && phase_done && !rs_r && en_r) |=>
      (done_r && code_r == twm_pkg::SC_START && state_r == twm_pkg::S_HOLD))
    else $error("START completion not reported as 08");

  a_ack_code: assert property (@(posedge clock) disable iff (rst)
    ((state_r == twm_pkg::S_ACK_H) && phase_done && addr_ph_r) |=>
      (done_r && code_r == ($past(sda_s) ? twm_pkg::SC_ADR_NAK : twm_pkg::SC_ADR_ACK)))
    else $error("address completion code wrong");

  a_data_code: assert property (@(posedge clock) disable iff (rst)
    ((state_r == twm_pkg::S_ACK_H) && phase_done && !addr_ph_r) |=>
      (code_r == ($past(sda_s) ? twm_pkg::SC_DAT_NAK : twm_pkg::SC_DAT_ACK)))
    else $error("data completion code wrong");

  a_hold_scl_low: assert property (@(posedge clock) disable iff (rst)
    (state_r == twm_pkg::S_HOLD && done_r) |-> scl_oe)
    else $error("SCL released while flag set");

  a_stop_no_flag: assert property (@(posedge clock) disable iff (rst)
    (state_r == twm_pkg::S_STOP_C && phase_done && en_r) |=>
      (!done_r && !sto_r && state_r == twm_pkg::S_IDLE))
    else $error("STOP set done flag or left stop request");

  a_dir_bit_drive: assert property (@(posedge clock) disable iff (rst)
    (state_r == twm_pkg::S_BIT_H) |-> (sda_oe == !shift_r[7]))
    else $error("SDA does not follow shifted bit");

  a_bit_low_hold: assert property (@(posedge clock) disable iff (rst)
    (state_r == twm_pkg::S_BIT_L && $past(state_r) == twm_pkg::S_BIT_L) |-> $stable(sda_oe))
    else $error("SDA moved during SCL low phase of a bit");

  a_lost_release: assert property (@(posedge clock) disable iff (rst)
    lost_evt |=> (done_r && code_r == twm_pkg::SC_ARB_LOST && !sda_oe && !scl_oe))
    else $error("arbitration loss not reported or bus kept");

  c_start_sent: cover property (@(posedge clock) disable iff (rst)
    (state_r == twm_pkg::S_START_END) ##1 (state_r == twm_pkg::S_HOLD));
  c_addr_acked: cover property (@(posedge clock) disable iff (rst)
    set_done && code_nxt == twm_pkg::SC_ADR_ACK);
  c_data_acked: cover property (@(posedge clock) disable iff (rst)
    set_done && code_nxt == twm_pkg::SC_DAT_ACK);
  c_stop_sent: cover property (@(posedge clock) disable iff (rst)
    (state_r == twm_pkg::S_STOP_C) ##1 (state_r == twm_pkg::S_IDLE));
  c_arb_lost: cover property (@(posedge clock) disable iff (rst) lost_evt);
endmodule

// ===== testbench/twm_slave_model.sv
// Behavioural slave receiver that listens on the two-wire bus
`timescale 1ns/100ps
module twm_slave_model (
  input  wire logic       scl,        // SCL wire level
  input  wire logic       sda,        // SDA wire level
  input  wire logic       ack_on,     // Acknowledge bytes when high
  output logic            sda_pull,   // Pulls SDA low when high
  output logic [7:0]      last_byte,  // Last byte received
  output int              stops       // STOP conditions seen
);
  logic       active;
  logic [3:0] bit_cnt;
  logic [7:0] shift;

  initial begin
    active = 1'b0;
    bit_cnt = 4'h0;
    shift = 8'h00;
    sda_pull = 1'b0;
    last_byte = 8'h00;
    stops = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // START: SDA falls while SCL is high; looked at 1 ns later, since SDA may
  // move in the same step as a falling SCL and must not count as a condition
  always @(negedge sda) begin
    #1;
    if (scl === 1'b1) begin
      active = 1'b1;
      bit_cnt = 4'h0;
    end
  end

  // STOP: SDA rises while SCL is high, frame ends
  always @(posedge sda) begin
    #1;
    if (scl === 1'b1) begin
      active = 1'b0;
      sda_pull = 1'b0;
      stops++;
    end
  end

  // Eight data bits MSB first, ninth clock is the acknowledge slot
  always @(posedge scl) begin
    if (active) begin
      if (bit_cnt == 4'h8) begin
        bit_cnt = 4'h0;
      end else begin
        shift = {shift[6:0], sda};
        bit_cnt = bit_cnt + 4'h1;
        if (bit_cnt == 4'h8) begin
          last_byte = shift;
        end
      end
    end
  end

  // Pull SDA only through the ninth low and high phases; released on the next falling SCL
  always @(negedge scl) begin
    sda_pull = active && ack_on && (bit_cnt == 4'h8);
  end
endmodule

// ===== testbench/twm_master_bench.sv
// Self-checking bench for the two-wire master transmitter
`timescale 1ns/100ps
module twm_master_bench;
  logic       clock;     // System clock
  logic       rst;       // Reset
  logic [1:0] addr;      // Register index
  logic [7:0] wdata;     // Write data
  logic       wr;        // Write strobe
  logic       rd;        // Read strobe
  logic [7:0] rdata;     // Read data
  logic [7:0] bit_rate;  // Phase length minus one
  logic       scl_oe;    // Master pulls SCL
  logic       sda_oe;    // Master pulls SDA
  logic       scl_o;     // SCL drive value
  logic       sda_o;     // SDA drive value
  logic       sl_pull;   // Slave pulls SDA
  logic       ext_pull;  // Foreign master pulls SDA
  logic       ack_on;    // Slave acknowledges
  logic       scl_w;     // SCL wire
  logic       sda_w;     // SDA wire
  logic [7:0] last_byte; // Byte seen by slave
  logic [7:0] d;         // Read result
  int         stops;     // STOP count from slave
  int         s0;        // STOP count snapshot
  int         fails;     // Mismatches
  int         compares;  // Comparisons
  int         cyc;       // Cycle count

  // Open-drain wires with pull-ups
  assign scl_w = ~scl_oe;
  assign sda_w = ~(sda_oe | sl_pull | ext_pull);

  twm_master #(.BR_W(8)) twm_master_i (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .bit_rate(bit_rate), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe)
  );

  twm_slave_model twm_slave_model_i (
    .scl(scl_w), .sda(sda_w), .ack_on(ack_on), .sda_pull(sl_pull),
    .last_byte(last_byte), .stops(stops)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 40 ns period
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Hang guard, well above the fewer than a thousand cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port tasks
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_stat(input logic [7:0] exp);
    logic [7:0] v;
    rd_reg(twm_pkg::ADDR_STAT, v);
    chk(v & twm_pkg::STAT_MASK, exp);
  endtask

  task automatic chk_oe(input logic [7:0] exp);
    chk({6'h00, scl_oe, sda_oe}, exp);
  endtask

  // Poll the done flag with a bounded number of reads
  task automatic wait_done;
    logic [7:0] v;
    int         n;
    v = 8'h00;
    n = 0;
    while (v[7] !== 1'b1 && n < 200) begin
      rd_reg(twm_pkg::ADDR_CTRL, v);
      n++;
    end
    chk({7'h00, v[7]}, 8'h01);
  endtask

  task automatic wait_stop;
    int n;
    n = 0;
    while (stops == s0 && n < 400) begin
      @(posedge clock);
      n++;
    end
    chk(8'(stops - s0), 8'h01);
  endtask

  task automatic wrap_up;
    $display("compares %0d, fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    rst = 1'b1;
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    bit_rate = 8'h03;  // Four cycles a low phase, six a high one with the synchroniser delay, give a 400 ns SCL period
    ext_pull = 1'b0;
    ack_on = 1'b1;
    fails = 0;
    compares = 0;
    cyc = 0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd_reg(twm_pkg::ADDR_CTRL, d);
    chk(d, 8'h00);
    rd_reg(twm_pkg::ADDR_STAT, d);
    chk(d, twm_pkg::CODE_RST);
    rd_reg(twm_pkg::ADDR_DATA, d);
    chk(d, twm_pkg::DATA_RST);
    rd_reg(2'h3, d);
    chk(d, 8'h00);
    // Prescaler field stays set, so every later code compare needs the mask
    wr_reg(twm_pkg::ADDR_STAT, 8'h03);
    rd_reg(twm_pkg::ADDR_STAT, d);
    chk(d, twm_pkg::CODE_RST | 8'h03);
    $display("reset values test done");
    // Zero in the flag position must not set it; start without enable stays idle
    wr_reg(twm_pkg::ADDR_CTRL, 8'h45);
    rd_reg(twm_pkg::ADDR_CTRL, d);
    chk(d, 8'h45);
    wr_reg(twm_pkg::ADDR_CTRL, 8'hA0);
    repeat (60) @(posedge clock);
    #1 chk_oe(8'h00);
    rd_reg(twm_pkg::ADDR_CTRL, d);
    chk(d, 8'h20);
    wr_reg(twm_pkg::ADDR_CTRL, 8'h00);
    $display("enable gate test done");
    // Full write: START, address, two bytes, STOP
    wr_reg(twm_pkg::ADDR_CTRL, 8'hA4);
    wait_done;
    chk_stat(twm_pkg::SC_START);
    repeat (50) @(posedge clock);
    #1 chk({4'h0, scl_o, sda_o, scl_oe, sda_oe}, 8'h03);
    wr_reg(twm_pkg::ADDR_DATA, 8'hA0);
    wr_reg(twm_pkg::ADDR_CTRL, 8'h84);
    wr_reg(twm_pkg::ADDR_DATA, 8'h55);
    rd_reg(twm_pkg::ADDR_CTRL, d);
    chk(d & 8'h08, 8'h08);
    wait_done;
    chk_stat(twm_pkg::SC_ADR_ACK);
    chk(last_byte, 8'hA0);
    wr_reg(twm_pkg::ADDR_DATA, 8'h3C);
    wr_reg(twm_pkg::ADDR_CTRL, 8'h84);
    wait_done;
    chk_stat(twm_pkg::SC_DAT_ACK);
    chk(last_byte, 8'h3C);
    ack_on = 1'b0;
    wr_reg(twm_pkg::ADDR_DATA, 8'hC3);
    wr_reg(twm_pkg::ADDR_CTRL, 8'h84);
    wait_done;
    chk_stat(twm_pkg::SC_DAT_NAK);
    chk(last_byte, 8'hC3);
    s0 = stops;
    wr_reg(twm_pkg::ADDR_CTRL, 8'h94);
    wait_stop;
    repeat (40) @(posedge clock);
    rd_reg(twm_pkg::ADDR_CTRL, d);
    chk(d, 8'h04);
    chk_oe(8'h00);
    $display("byte transfer test done");
    // Address refused, then repeated START with read direction
    wr_reg(twm_pkg::ADDR_CTRL, 8'hA4);
    wait_done;
    chk_stat(twm_pkg::SC_START);
    wr_reg(twm_pkg::ADDR_DATA, 8'hA0);
    wr_reg(twm_pkg::ADDR_CTRL, 8'h84);
    wait_done;
    chk_stat(twm_pkg::SC_ADR_NAK);
    ack_on = 1'b1;
    wr_reg(twm_pkg::ADDR_CTRL, 8'hA4);
    wait_done;
    chk_stat(twm_pkg::SC_RSTART);
    wr_reg(twm_pkg::ADDR_DATA, 8'hA1);
    wr_reg(twm_pkg::ADDR_CTRL, 8'h84);
    wait_done;
    chk_stat(twm_pkg::SC_ADR_ACK);
    chk(last_byte, 8'hA1);
    s0 = stops;
    wr_reg(twm_pkg::ADDR_CTRL, 8'h94);
    wait_stop;
    $display("repeated start test done");
    // Foreign master holds the bus, then wins arbitration on the first bit
    ext_pull = 1'b1;
    repeat (10) @(posedge clock);
    wr_reg(twm_pkg::ADDR_CTRL, 8'hA4);
    repeat (60) @(posedge clock);
    #1 chk_oe(8'h00);
    ext_pull = 1'b0;
    wait_done;
    chk_stat(twm_pkg::SC_START);
    ext_pull = 1'b1;
    wr_reg(twm_pkg::ADDR_DATA, 8'hA0);
    wr_reg(twm_pkg::ADDR_CTRL, 8'h84);
    wait_done;
    chk_stat(twm_pkg::SC_ARB_LOST);
    chk_oe(8'h00);
    wr_reg(twm_pkg::ADDR_CTRL, 8'h84);
    repeat (20) @(posedge clock);
    rd_reg(twm_pkg::ADDR_CTRL, d);
    chk(d, 8'h04);
    chk_oe(8'h00);
    ext_pull = 1'b0;
    repeat (20) @(posedge clock);
    $display("arbitration test done");
    wrap_up;
  end
endmodule
